// File: cbl_bus_latch.sv
// Address latch, strobe generation, timebase and self-test exit logic.
`timescale 1ns/1ns
module cbl_bus_latch
    import cbl_pkg::*;
(
    input wire logic clk_i,                    // Processor clock, 100 MHz.
    input wire logic rst_b_i,                  // Asynchronous reset, active low.
    input wire logic address_strobe_i,         // Address strobe pin, active high.
    input wire logic data_strobe_b_i,          // Data strobe pin, active low.
    input wire logic read_not_write_i,         // High for read, low for write.
    input wire logic mem_not_io_i,             // High for memory, low for I/O.
    input wire logic selftest_en_b_i,          // Self-test enable pin, active low.
    input wire logic [15:0] info_bus_i,        // Information bus input value.
    output logic [15:0] info_bus_o,            // Information bus drive value.
    output logic info_bus_oe_b_o,              // Information bus drive enable, active low.
    output logic [15:0] addr_o,                // Latched address.
    output logic mem_read_strobe_b_o,          // Memory read strobe, active low.
    output logic mem_write_strobe_b_o,         // Memory write strobe, active low.
    output logic io_read_strobe_b_o,           // I/O read strobe, active low.
    output logic io_write_strobe_b_o,          // I/O write strobe, active low.
    output logic selftest_done_o,              // Self-test done, active high.
    output logic timebase_clk_o                // 100 kHz timebase.
);
    // =====================================================================
    // Input synchronisers
    // =====================================================================
    logic [19:0] s1_r;
    logic [19:0] s2_r;
    logic [19:0] s_in;
    logic en_b_1_r;
    logic en_b_2_r;
    logic as_s;
    logic ds_b_s;
    logic rw_s;
    logic mio_s;
    logic [15:0] ib_s;
    logic ds_b_d_r;

    assign s_in = {address_strobe_i, data_strobe_b_i, read_not_write_i, mem_not_io_i, info_bus_i};
    assign {as_s, ds_b_s, rw_s, mio_s, ib_s} = s2_r;

    // Two flip-flops on every pin input.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r <= 20'h40000;
            s2_r <= 20'h40000;
            ds_b_d_r <= 1'b1;
        end else begin
            s1_r <= s_in;
            s2_r <= s1_r;
            ds_b_d_r <= ds_b_s;
        end
    end

    // The enable strap has no reset, so it already shows the pin when reset is released.
    always_ff @(posedge clk_i) begin
        en_b_1_r <= selftest_en_b_i;
        en_b_2_r <= en_b_1_r;
    end

    logic ds_rise;
    logic ds_fall;
    assign ds_rise = ~ds_b_d_r & ds_b_s;
    assign ds_fall = ds_b_d_r & ~ds_b_s;

    // =====================================================================
    // Address latch and strobes
    // =====================================================================
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic mr_r, mw_r, ir_r, iw_r;
    logic mr_nxt, mw_nxt, ir_nxt, iw_nxt;

    // Follow the bus while the address strobe is high, hold afterwards.
    always_comb begin
        addr_nxt = as_s ? ib_s : addr_r;
        mr_nxt = ~(~ds_b_s & rw_s & mio_s);
        mw_nxt = ~(~ds_b_s & ~rw_s & mio_s);
        ir_nxt = ~(~ds_b_s & rw_s & ~mio_s);
        iw_nxt = ~(~ds_b_s & ~rw_s & ~mio_s);
    end

    // Register latch and strobes.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_r <= CBL_ADDR_RST;
            mr_r <= 1'b1;
            mw_r <= 1'b1;
            ir_r <= 1'b1;
            iw_r <= 1'b1;
        end else begin
            addr_r <= addr_nxt;
            mr_r <= mr_nxt;
            mw_r <= mw_nxt;
            ir_r <= ir_nxt;
            iw_r <= iw_nxt;
        end
    end

    // =====================================================================
    // Self-test exit sequencer
    // =====================================================================
    cbl_state_t st_r;
    cbl_state_t st_nxt;
    logic done_r, done_nxt;
    logic [15:0] dout_r, dout_nxt;
    logic oe_b_r, oe_b_nxt;
    logic init_r;
    logic mem_rd_go;

    // Start of a memory read data phase.
    assign mem_rd_go = ds_fall & rw_s & mio_s;

    // Step through the exit reads and drive the two supplied words.
    always_comb begin
        st_nxt = st_r;
        done_nxt = done_r;
        dout_nxt = dout_r;
        oe_b_nxt = oe_b_r;
        case (st_r)
            CBL_ST_RUN: begin
                done_nxt = 1'b0;
                if (ds_fall && !rw_s && !mio_s && addr_r == CBL_EXIT_IO_ADDR) begin
                    st_nxt = CBL_ST_WAIT_RD0;
                end
            end
            CBL_ST_WAIT_RD0: begin
                if (mem_rd_go) begin
                    st_nxt = CBL_ST_RD0;
                    dout_nxt = CBL_EXIT_WORD0;
                    oe_b_nxt = 1'b0;
                end
            end
            CBL_ST_RD0: begin
                if (ds_rise) begin
                    st_nxt = CBL_ST_WAIT_RD1;
                    oe_b_nxt = 1'b1;
                end
            end
            CBL_ST_WAIT_RD1: begin
                if (mem_rd_go) begin
                    st_nxt = CBL_ST_RD1;
                    dout_nxt = CBL_EXIT_WORD1;
                    oe_b_nxt = 1'b0;
                end
            end
            CBL_ST_RD1: begin
                if (ds_rise) begin
                    st_nxt = CBL_ST_DONE;
                    oe_b_nxt = 1'b1;
                    done_nxt = 1'b1;
                end
            end
            CBL_ST_DONE: begin
                oe_b_nxt = 1'b1;
                done_nxt = 1'b1;
            end
            default: begin
                st_nxt = CBL_ST_RUN;
                oe_b_nxt = 1'b1;
            end
        endcase
        if (init_r) begin
            st_nxt = en_b_2_r ? CBL_ST_DONE : CBL_ST_RUN;
            done_nxt = en_b_2_r;
            oe_b_nxt = 1'b1;
        end
    end

    // Register sequencer; the enable strap is taken in the first cycle after release.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= CBL_ST_RUN;
            done_r <= 1'b0;
            dout_r <= 16'h0000;
            oe_b_r <= 1'b1;
            init_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            done_r <= done_nxt;
            dout_r <= dout_nxt;
            oe_b_r <= oe_b_nxt;
            init_r <= 1'b0;
        end
    end

    // =====================================================================
    // Timebase
    // =====================================================================
    cbl_timebase u_timebase (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .tick_clk_o(timebase_clk_o)
    );

    assign addr_o = addr_r;
    assign mem_read_strobe_b_o = mr_r;
    assign mem_write_strobe_b_o = mw_r;
    assign io_read_strobe_b_o = ir_r;
    assign io_write_strobe_b_o = iw_r;
    assign selftest_done_o = done_r;
    assign info_bus_o = dout_r;
    assign info_bus_oe_b_o = oe_b_r;

    // =====================================================================
    // Assertions
    // =====================================================================
    property p_done_drive;
        @(posedge clk_i) disable iff (!rst_b_i)
        done_r |-> oe_b_r;
    endproperty
    a_done_drive: assert property (p_done_drive) else $error("Data driven after self-test done.");

    property p_done_rise;
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(done_r) && !$past(init_r) |-> $past(st_r) == CBL_ST_RD1 && $past(ds_rise);
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("Done rose outside end of second read.");

    property p_word0;
        @(posedge clk_i) disable iff (!rst_b_i)
        st_r == CBL_ST_WAIT_RD0 && mem_rd_go |=> !oe_b_r && dout_r == CBL_EXIT_WORD0;
    endproperty
    a_word0: assert property (p_word0) else $error("First exit word wrong.");

    property p_word1;
        @(posedge clk_i) disable iff (!rst_b_i)
        st_r == CBL_ST_WAIT_RD1 && mem_rd_go |=> !oe_b_r && dout_r == CBL_EXIT_WORD1;
    endproperty
    a_word1: assert property (p_word1) else $error("Second exit word wrong.");

    property p_exit_start;
        @(posedge clk_i) disable iff (!rst_b_i)
        st_r == CBL_ST_RUN && !init_r && ds_fall && !rw_s && !mio_s && addr_r == CBL_EXIT_IO_ADDR
            |=> st_r == CBL_ST_WAIT_RD0;
    endproperty
    a_exit_start: assert property (p_exit_start) else $error("Exit I/O write not seen.");

    property p_latch;
        @(posedge clk_i) disable iff (!rst_b_i)
        as_s |=> addr_r == $past(ib_s);
    endproperty
    a_latch: assert property (p_latch) else $error("Address not latched.");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
        !as_s |=> $stable(addr_r);
    endproperty
    a_hold: assert property (p_hold) else $error("Address changed outside strobe.");

    property p_mem_read;
        @(posedge clk_i) disable iff (!rst_b_i)
        !ds_b_s && rw_s && mio_s |=> !mr_r && mw_r && iw_r;
    endproperty
    a_mem_read: assert property (p_mem_read) else $error("Memory read strobe wrong.");

    property p_no_test;
        @(posedge clk_i) disable iff (!rst_b_i)
        init_r && en_b_2_r |=> done_r [*2];
    endproperty
    a_no_test: assert property (p_no_test) else $error("Done not high with test disabled.");

    property p_test_on;
        @(posedge clk_i) disable iff (!rst_b_i)
        init_r && !en_b_2_r |=> !done_r && st_r == CBL_ST_RUN;
    endproperty
    a_test_on: assert property (p_test_on) else $error("Self-test skipped while enabled.");

    property p_run_low;
        @(posedge clk_i) disable iff (!rst_b_i)
        st_r == CBL_ST_RUN && !init_r |-> !done_r;
    endproperty
    a_run_low: assert property (p_run_low) else $error("Done high during self-test.");

    c_exit: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(done_r) && !$past(init_r));
    c_word0: cover property (@(posedge clk_i) disable iff (!rst_b_i) st_r == CBL_ST_RD0);
    c_io_write: cover property (@(posedge clk_i) disable iff (!rst_b_i) !iw_r);
endmodule // cbl_bus_latch

// File: cbl_pkg.sv
// Package of constants and types for the processor bus latch and self-test exit block.
package cbl_pkg;
    // =====================================================================
    // Bus widths and self-test exit values
    // =====================================================================
    localparam int CBL_BUS_W = 16;
    localparam logic [15:0] CBL_EXIT_IO_ADDR = 16'h1F44;
    localparam logic [15:0] CBL_EXIT_WORD0 = 16'h7070;
    localparam logic [15:0] CBL_EXIT_WORD1 = 16'h0000;
    localparam logic [15:0] CBL_ADDR_RST = 16'h0000;
    // =====================================================================
    // Timebase
    // =====================================================================
    localparam int CBL_CLK_HZ = 100_000_000;
    localparam int CBL_TICK_HZ = 100_000;
    localparam int CBL_TICK_HALF_CYC = CBL_CLK_HZ / (2 * CBL_TICK_HZ);
    localparam int CBL_DIV_W = 16;
    // Self-test exit sequencer states.
    typedef enum logic [2:0] {
        CBL_ST_RUN,
        CBL_ST_WAIT_RD0,
        CBL_ST_RD0,
        CBL_ST_WAIT_RD1,
        CBL_ST_RD1,
        CBL_ST_DONE
    } cbl_state_t;
endpackage : cbl_pkg

// File: cbl_timebase.sv
// Divider that makes the fixed 100 kHz timebase from the processor clock.
`timescale 1ns/1ns
module cbl_timebase
    import cbl_pkg::*;
#(
    parameter logic [CBL_DIV_W-1:0] HALF_CYC = CBL_DIV_W'(CBL_TICK_HALF_CYC)
) (
    input wire logic clk_i,    // Processor clock.
    input wire logic rst_b_i,  // Asynchronous reset, active low.
    output logic tick_clk_o    // 100 kHz square wave.
);
    logic [CBL_DIV_W-1:0] cnt_r;
    logic [CBL_DIV_W-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // =====================================================================
    // Divider
    // =====================================================================
    // Toggle the output every half period of the timebase.
    always_comb begin
        cnt_nxt = cnt_r + 16'h0001;
        tick_nxt = tick_r;
        if (cnt_r == HALF_CYC - 16'h0001) begin
            cnt_nxt = 16'h0000;
            tick_nxt = ~tick_r;
        end
    end

    // Register the divider state.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_clk_o = tick_r;

    // Half period holds for exactly HALF_CYC cycles.
    property p_tick_period;
        @(posedge clk_i) disable iff (!rst_b_i)
        $changed(tick_r) |-> cnt_r == 16'h0000;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("Timebase toggled off count.");
endmodule // cbl_timebase

// File: cbl_cpu_model.sv
// Processor model that runs whole bus cycles on the multiplexed information bus.
`timescale 1ns/1ns
module cbl_cpu_model (
    input wire logic clk_i,            // Processor clock.
    input wire logic [15:0] bus_i,     // Resolved information bus level.
    input wire logic [3:0] strobes_i,  // Memory read, memory write, I/O read, I/O write strobes, active low.
    output logic address_strobe_o,     // Address strobe, active high.
    output logic data_strobe_b_o,      // Data strobe, active low.
    output logic read_not_write_o,     // High for read, low for write.
    output logic mem_not_io_o,         // High for memory, low for I/O.
    output logic bus_oe_b_o,           // Low while the model drives the bus.
    output logic [15:0] bus_o          // Value the model drives.
);
    // =====================================================================
    // Idle state
    // =====================================================================
    // The model starts idle with the bus released.
    initial begin
        address_strobe_o = 1'b0;
        data_strobe_b_o = 1'b1;
        read_not_write_o = 1'b1;
        mem_not_io_o = 1'b1;
        bus_oe_b_o = 1'b1;
        bus_o = 16'h0000;
    end

    // =====================================================================
    // Bus cycle
    // =====================================================================
    // One cycle: address phase, data phase, then an idle gap for the strobes to clear.
    task automatic cycle(input logic [15:0] addr, input logic rd, input logic mem, input logic [15:0] wdata,
                         output logic [15:0] rdata, output logic [3:0] stb);
        @(posedge clk_i);
        #1;
        bus_o = addr;
        bus_oe_b_o = 1'b0;
        read_not_write_o = rd;
        mem_not_io_o = mem;
        address_strobe_o = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        address_strobe_o = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        bus_o = wdata;
        bus_oe_b_o = rd; // The bus is released for reads so the answering party can drive it.
        data_strobe_b_o = 1'b0;
        repeat (6) @(posedge clk_i);
        rdata = bus_i;
        stb = strobes_i;
        #1;
        data_strobe_b_o = 1'b1;
        bus_oe_b_o = 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule // cbl_cpu_model

// File: cpu_bus_latch_selftest_exit_bench.sv
// Self-checking bench for the bus latch and self-test exit block.
`timescale 1ns/1ns
module cpu_bus_latch_selftest_exit_bench import cbl_pkg::*;;
    logic clk_i, rst_b_i, selftest_en_b;
    logic as_w, ds_b_w, rw_w, mio_w, cpu_oe_b, dut_oe_b, mr_b, mw_b, ir_b, iw_b, done, tb_clk;
    logic [15:0] cpu_bus, dut_bus, addr, bus_w;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;

    // The bus level is resolved from every driver; memory answers reads, else it keeps changing.
    assign bus_w = !dut_oe_b ? dut_bus : !cpu_oe_b ? cpu_bus : !mr_b ? ~addr : cyc[15:0];

    cbl_bus_latch u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .address_strobe_i(as_w), .data_strobe_b_i(ds_b_w),
        .read_not_write_i(rw_w), .mem_not_io_i(mio_w), .selftest_en_b_i(selftest_en_b), .info_bus_i(bus_w),
        .info_bus_o(dut_bus), .info_bus_oe_b_o(dut_oe_b), .addr_o(addr), .mem_read_strobe_b_o(mr_b),
        .mem_write_strobe_b_o(mw_b), .io_read_strobe_b_o(ir_b), .io_write_strobe_b_o(iw_b),
        .selftest_done_o(done), .timebase_clk_o(tb_clk));

    cbl_cpu_model u_cpu (.clk_i(clk_i), .bus_i(bus_w), .strobes_i({mr_b, mw_b, ir_b, iw_b}),
        .address_strobe_o(as_w), .data_strobe_b_o(ds_b_w), .read_not_write_o(rw_w), .mem_not_io_o(mio_w),
        .bus_oe_b_o(cpu_oe_b), .bus_o(cpu_bus));

    // =====================================================================
    // Clock, reset and timeout
    // =====================================================================
    // The clock runs at 100 MHz.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // A hang beyond the expected run length counts as a mismatch.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Resets the block with the self-test enable held steady around the release.
    task automatic do_reset(input logic en_b);
        @(posedge clk_i);
        #1;
        selftest_en_b = en_b;
        rst_b_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    // Runs one bus cycle and checks the read data against the expected value.
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic [3:0] s;
        u_cpu.cycle(a, 1'b1, 1'b1, 16'h0000, d, s);
        check(d, exp);
    endtask

    // Runs one I/O write cycle.
    task automatic io_wr(input logic [15:0] a);
        logic [15:0] d;
        logic [3:0] s;
        u_cpu.cycle(a, 1'b0, 1'b0, 16'h1234, d, s);
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    // Latching and strobe decode for every cycle kind with self-test disabled.
    task automatic t_latch();
        logic [15:0] tbl [4] = '{16'hFFFF, 16'h0000, 16'hA5C3, 16'h5A3C};
        logic [15:0] d;
        logic [3:0] s;
        do_reset(1'b1);
        check(16'(done), 16'h0001);
        for (int k = 0; k < 4; k++) begin
            u_cpu.cycle(tbl[k], k[1], k[0], ~tbl[k], d, s);
            check(addr, tbl[k]);
            check(16'(s), 16'({!(k[1] && k[0]), !(!k[1] && k[0]), !(k[1] && !k[0]), !(!k[1] && !k[0])}));
            if (k == 3) check(d, ~tbl[k]);
        end
        $display("test latch and strobes finished");
    endtask

    // Full self-test exit, with a decoy I/O write and read ahead of it.
    task automatic t_exit();
        do_reset(1'b0);
        check(16'(done), 16'h0000);
        io_wr(16'h1F45);
        rd_chk(16'h0100, 16'hFEFF);
        io_wr(CBL_EXIT_IO_ADDR);
        rd_chk(16'h0100, CBL_EXIT_WORD0);
        check(16'(done), 16'h0000);
        rd_chk(16'h0101, CBL_EXIT_WORD1);
        check(16'(done), 16'h0001);
        rd_chk(16'h0102, 16'hFEFD);
        rd_chk(16'h0103, 16'hFEFC);
        rd_chk(16'h0000, 16'hFFFF);
        rd_chk(16'h0001, 16'hFFFE);
        $display("test self-test exit finished");
    endtask

    // A reset in mid-sequence returns the sequencer to its start.
    task automatic t_mid_reset();
        do_reset(1'b0);
        io_wr(CBL_EXIT_IO_ADDR);
        rd_chk(16'h0100, CBL_EXIT_WORD0);
        do_reset(1'b0);
        check(16'(done), 16'h0000);
        rd_chk(16'h0101, 16'hFEFE);
        $display("test reset in mid-sequence finished");
    endtask

    // Measures the high and low halves of the timebase on falling edges, where the output has settled.
    task automatic t_timebase();
        logic [15:0] n;
        for (int i = 0; i < 1200 && tb_clk !== 1'b0; i++) @(negedge clk_i);
        for (int i = 0; i < 1200 && tb_clk !== 1'b1; i++) @(negedge clk_i);
        n = 16'h0000;
        while (tb_clk === 1'b1 && n < 16'h0800) begin
            n++;
            @(negedge clk_i);
        end
        check(n, 16'(CBL_TICK_HALF_CYC));
        n = 16'h0000;
        while (tb_clk === 1'b0 && n < 16'h0800) begin
            n++;
            @(negedge clk_i);
        end
        check(n, 16'(CBL_TICK_HALF_CYC));
        $display("test timebase finished");
    endtask

    // Main sequence.
    initial begin
        rst_b_i = 1'b0;
        selftest_en_b = 1'b1;
        t_latch();
        t_exit();
        t_mid_reset();
        t_timebase();
        stop_test();
    end
endmodule // cpu_bus_latch_selftest_exit_bench
